//--- psr_monitor_model.sv
// Far-side model: press contact monitor and operator clear button.
// Assumes the bench changes requests just after a rising clock edge.
// ----------------------------------------------------------------
// Monitor model
// ----------------------------------------------------------------
module psr_monitor_model #(
    parameter int STROKE_CYC = 3
) (
    input  wire logic        clock,
    input  wire logic        main_req,
    input  wire logic        stroke_go,
    input  wire logic        clear_go,
    input  wire logic [15:0] clear_len,
    output logic             main_permit,
    output logic             stroke_end,
    output logic             clear_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  stroke_cnt_ff = 8'h00;
    logic [15:0] clear_cnt_ff  = 16'h0000;
    initial begin
        main_permit = 1'b1;
        stroke_end = 1'b0;
        clear_in = 1'b0;
    end
    // Main release follows the request one cycle late
    always @(posedge clock) main_permit <= main_req;
    // Stroke end comes a few cycles into the stroke, held until it stops
    always @(posedge clock) begin
        stroke_cnt_ff <= stroke_go ? stroke_cnt_ff + 8'(stroke_cnt_ff != 8'hFF) : 8'h00;
        stroke_end <= stroke_cnt_ff >= 8'(STROKE_CYC);
    end
    // Clear button held high for exactly the asked number of cycles
    always @(posedge clock) begin
        if (clear_go) begin
            clear_cnt_ff <= clear_len;
        end else if (clear_cnt_ff != 16'h0000) begin
            clear_cnt_ff <= clear_cnt_ff - 16'h0001;
        end
        clear_in <= clear_cnt_ff != 16'h0000;
    end
endmodule

//--- psr_release.sv
// Press setup release logic: permit output, restart interlock, AHB-Lite registers.
// Assumes all operator and monitor inputs are synchronous to the 100 MHz clock.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.

// ----------------------------------------------------------------------------
// Top module
// ----------------------------------------------------------------------------
module psr_release #(
    parameter logic [31:0] MIN_SHORT = 32'(psr_pkg::MIN_SHORT_CYC),
    parameter logic [31:0] MIN_LONG  = 32'(psr_pkg::MIN_LONG_CYC),
    parameter logic [31:0] MAX_HIGH  = 32'(psr_pkg::MAX_HIGH_CYC)
) (
    input  wire logic        clock,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Press signals
    input  wire logic        run_cmd,
    input  wire logic        main_permit,
    input  wire logic        start_permit,
    input  wire logic        stroke_end,
    input  wire logic        clear_in,
    output logic             press_permit,
    output logic             clear_pending,
    output logic             main_permit_n
);
    logic        hreadyout_ff;
    logic        hresp_ff;
    logic [31:0] hrdata_ff;
    logic        wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic [31:0] ctrl_ff;
    logic        run_prev_ff;
    logic        main_prev_ff;
    logic        stroke_prev_ff;
    logic        clear_lvl_ff;
    logic        interlock_ff;
    logic        nxt_interlock;
    logic        permit_ff;
    logic        nxt_permit;
    logic        pending_ff;
    logic        main_n_ff;
    logic        valid_pulse;
    logic        run_rise;
    logic        run_fall;
    logic        main_fall;
    logic        stroke_rise;
    logic        start_ok;
    logic        stop_event;
    logic [2:0]  mode;
    logic        addr_take;

    // ------------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------------

    // Unknown setting codes behave as the strictest setting
    function automatic logic [2:0] psr_mode(input logic [31:0] ctrl);
        logic [2:0] m;
        m = ctrl[psr_pkg::CTRL_MODE_MSB:psr_pkg::CTRL_MODE_LSB];
        if (m < psr_pkg::MODE_NONE || m > psr_pkg::MODE_STROKE)
            m = psr_pkg::MODE_ALWAYS;
        return m;
    endfunction

    assign mode      = psr_mode(ctrl_ff);
    assign addr_take = hsel && htrans[1] && hready;

    // Status word built from live block state
    function automatic logic [31:0] psr_status(input logic p, input logic q,
                                               input logic i, input logic n);
        logic [31:0] s;
        s = 32'h0000_0000;
        s[psr_pkg::ST_PERMIT]    = p;
        s[psr_pkg::ST_PENDING]   = q;
        s[psr_pkg::ST_INTERLOCK] = i;
        s[psr_pkg::ST_MAIN_N]    = n;
        s[psr_pkg::ST_RUN]       = run_prev_ff;
        s[psr_pkg::ST_MAIN]      = main_prev_ff;
        s[psr_pkg::ST_START]     = start_permit;
        s[psr_pkg::ST_STROKE]    = stroke_prev_ff;
        s[psr_pkg::ST_CLEAR]     = clear_lvl_ff;
        return s;
    endfunction

    // Bus handshake; zero wait states, always OKAY
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    // Read data captured at address phase so it stands in the data phase
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            unique case (haddr)
                psr_pkg::OFS_CTRL:   hrdata_ff <= ctrl_ff;
                psr_pkg::OFS_STATUS: hrdata_ff <= psr_status(permit_ff, pending_ff,
                                                             interlock_ff, main_n_ff);
                default:             hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Write address held until the data phase delivers hwdata
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
        end else begin
            wr_pend_ff <= addr_take && hwrite;
            if (addr_take)
                wr_addr_ff <= haddr;
        end
    end

    // Control register; unused bits read back as zero
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctrl_ff <= psr_pkg::CTRL_RST;
        end else if (wr_pend_ff && wr_addr_ff == psr_pkg::OFS_CTRL) begin
            ctrl_ff <= hwdata & 32'h0000_003F;
        end
    end

    // ------------------------------------------------------------------------
    // Input sampling and edges
    // ------------------------------------------------------------------------

    // Previous-cycle copies for edge detection and the status word
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            run_prev_ff    <= 1'b0;
            main_prev_ff   <= 1'b0;
            stroke_prev_ff <= 1'b0;
            clear_lvl_ff   <= 1'b0;
        end else begin
            run_prev_ff    <= run_cmd;
            main_prev_ff   <= main_permit;
            stroke_prev_ff <= stroke_end;
            clear_lvl_ff   <= clear_in;
        end
    end

    assign run_rise    = run_cmd && !run_prev_ff;
    assign run_fall    = !run_cmd && run_prev_ff;
    assign main_fall   = !main_permit && main_prev_ff;
    assign stroke_rise = ctrl_ff[psr_pkg::CTRL_STROKE_EN] && stroke_end && !stroke_prev_ff;
    // Start permit only matters when enabled
    assign start_ok    = !ctrl_ff[psr_pkg::CTRL_START_EN] || start_permit;

    // Clear pulse measurement
    psr_timer #(
        .MIN_SHORT (MIN_SHORT),
        .MIN_LONG  (MIN_LONG),
        .MAX_HIGH  (MAX_HIGH)
    ) u_timer (
        .clock       (clock),
        .reset_n     (reset_n),
        .clear_in    (clear_in),
        .min_long    (ctrl_ff[psr_pkg::CTRL_MIN_LONG]),
        .valid_pulse (valid_pulse)
    );

    // ------------------------------------------------------------------------
    // Restart interlock
    // ------------------------------------------------------------------------

    // Stops that re-arm, per setting; run and stroke stops count only while running
    always_comb begin
        unique case (mode)
            psr_pkg::MODE_ALWAYS: stop_event = main_fall
                                  || (permit_ff && (run_fall || stroke_rise));
            psr_pkg::MODE_RUN:    stop_event = main_fall || (permit_ff && run_fall);
            psr_pkg::MODE_STROKE: stop_event = main_fall || (permit_ff && stroke_rise);
            default:              stop_event = 1'b0;
        endcase
    end

    // Re-arm wins over a clear that lands in the same cycle
    always_comb begin
        nxt_interlock = interlock_ff;
        if (mode == psr_pkg::MODE_NONE)
            nxt_interlock = 1'b0;
        else if (stop_event)
            nxt_interlock = 1'b1;
        else if (valid_pulse && pending_ff)
            nxt_interlock = 1'b0;
    end

    // Reset arms it, matching the default strict setting
    always_ff @(posedge clock) begin
        if (!reset_n)
            interlock_ff <= 1'b1;
        else
            interlock_ff <= nxt_interlock;
    end

    // Pending shown only while a clear could actually be accepted
    always_ff @(posedge clock) begin
        if (!reset_n)
            pending_ff <= 1'b0;
        else
            pending_ff <= nxt_interlock && main_permit && start_ok;
    end

    // ------------------------------------------------------------------------
    // Press permit
    // ------------------------------------------------------------------------

    // One register stage of latency; main low wins over everything
    always_comb begin
        nxt_permit = permit_ff;
        if (!main_permit)
            nxt_permit = 1'b0;
        else if (permit_ff) begin
            if (run_fall)
                nxt_permit = 1'b0;
            else if (stroke_rise)
                nxt_permit = 1'b0;
        end else if (run_rise && start_ok && !nxt_interlock)
            nxt_permit = 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!reset_n)
            permit_ff <= 1'b0;
        else
            permit_ff <= nxt_permit;
    end

    // Inverted copy of the main permit
    always_ff @(posedge clock) begin
        if (!reset_n)
            main_n_ff <= 1'b1;
        else
            main_n_ff <= !main_permit;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hreadyout     = hreadyout_ff;
    assign hresp         = hresp_ff;
    assign hrdata        = hrdata_ff;
    assign press_permit  = permit_ff;
    assign clear_pending = pending_ff;
    assign main_permit_n = main_n_ff;

    // hsize unused: only whole-word transfers are supported
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, htrans[0]};
endmodule

//--- psr_release_assertions.sv
// Checker for the press setup release block, watching top ports only.
// Assumes one clock domain and the synchronous active-low reset.
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module psr_release_chk #(
    parameter logic [31:0] MIN_SHORT = 32'h0000_000A,
    parameter logic [31:0] MAX_HIGH  = 32'h0000_012C
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic run_cmd,
    input wire logic main_permit,
    input wire logic clear_in,
    input wire logic press_permit,
    input wire logic clear_pending,
    input wire logic main_permit_n
);
    logic [31:0] hi_cnt_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Length of the current clear high phase, in cycles
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hi_cnt_ff <= 32'h0000_0000;
        end else begin
            hi_cnt_ff <= clear_in ? hi_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    inv_main_a: assert property ($past(reset_n) |-> main_permit_n == !$past(main_permit))
        else $error("inverted main permit wrong");
    main_drop_a: assert property ($past(reset_n) && !$past(main_permit) |-> !press_permit)
        else $error("permit high with main permit low");
    no_both_a: assert property (!(press_permit && clear_pending))
        else $error("permit and pending both high");
    run_fall_a: assert property ($fell(run_cmd) && $past(reset_n) |=> !press_permit)
        else $error("permit kept after run fall");
    // Only a fresh run edge with main permit and no pending clear raises it
    permit_rise_a: assert property ($rose(press_permit) |-> $past(run_cmd)
        && !$past(run_cmd, 2) && $past(main_permit) && !$past(clear_pending))
        else $error("permit rose without its cause");
    // A clear that ends pending must have had an in-range high phase;
    // the count sampled on the judging edge still holds the full high length
    clear_len_a: assert property ($fell(clear_pending) && $past(main_permit)
        && $past(main_permit, 2) |-> $past(hi_cnt_ff) >= MIN_SHORT
        && $past(hi_cnt_ff) <= MAX_HIGH)
        else $error("pending dropped without valid clear");
    pending_rise_a: assert property ($rose(clear_pending) |-> $past(main_permit))
        else $error("pending rose with main permit low");
    reset_arm_a: assert property ($rose(reset_n) && main_permit |-> ##[1:2] clear_pending)
        else $error("interlock not armed after reset");
    cover property ($rose(press_permit));
    cover property ($fell(clear_pending));
    cover property ($past(reset_n) && $rose(clear_pending));
endmodule

bind psr_release psr_release_chk #(.MIN_SHORT(MIN_SHORT), .MAX_HIGH(MAX_HIGH)) u_chk (
    .clock(clock), .reset_n(reset_n), .run_cmd(run_cmd), .main_permit(main_permit),
    .clear_in(clear_in), .press_permit(press_permit), .clear_pending(clear_pending),
    .main_permit_n(main_permit_n));

//--- psr_timer.sv
// Shared constants for the press setup release logic, and the clear pulse timer.
// Assumes one 100 MHz clock and inputs already synchronous to it.

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package psr_pkg;
    // Clock rate and timing figures
    localparam longint CLK_HZ          = 100_000_000;
    localparam longint MIN_SHORT_MS    = 100;
    localparam longint MIN_LONG_MS     = 350;
    localparam longint MAX_HIGH_S      = 30;
    localparam longint MIN_SHORT_CYC   = (MIN_SHORT_MS * CLK_HZ + 999) / 1000;
    localparam longint MIN_LONG_CYC    = (MIN_LONG_MS * CLK_HZ + 999) / 1000;
    localparam longint MAX_HIGH_CYC    = MAX_HIGH_S * CLK_HZ;
    localparam int     CNT_W           = 32;

    // Register byte offsets
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;

    // Control field positions
    localparam int CTRL_MODE_LSB       = 0;
    localparam int CTRL_MODE_MSB       = 2;
    localparam int CTRL_START_EN       = 3;
    localparam int CTRL_STROKE_EN      = 4;
    localparam int CTRL_MIN_LONG       = 5;

    // Status field positions
    localparam int ST_PERMIT           = 0;
    localparam int ST_PENDING          = 1;
    localparam int ST_INTERLOCK        = 2;
    localparam int ST_MAIN_N           = 3;
    localparam int ST_RUN              = 4;
    localparam int ST_MAIN             = 5;
    localparam int ST_START            = 6;
    localparam int ST_STROKE           = 7;
    localparam int ST_CLEAR            = 8;

    // Interlock setting codes
    localparam logic [2:0] MODE_NONE   = 3'h1;
    localparam logic [2:0] MODE_ALWAYS = 3'h2;
    localparam logic [2:0] MODE_RUN    = 3'h3;
    localparam logic [2:0] MODE_STROKE = 3'h4;

    // Reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0002;
endpackage

// ----------------------------------------------------------------------------
// Clear pulse timer
// ----------------------------------------------------------------------------
module psr_timer #(
    parameter logic [31:0] MIN_SHORT = 32'(psr_pkg::MIN_SHORT_CYC),
    parameter logic [31:0] MIN_LONG  = 32'(psr_pkg::MIN_LONG_CYC),
    parameter logic [31:0] MAX_HIGH  = 32'(psr_pkg::MAX_HIGH_CYC)
) (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic clear_in,
    input  wire logic min_long,
    output logic      valid_pulse
);
    logic        clear_prev_ff;
    logic [31:0] high_cnt_ff;
    logic [31:0] min_cyc;

    // Pick the configured minimum high time
    assign min_cyc = min_long ? MIN_LONG : MIN_SHORT;

    // High time counter, saturating just past the upper limit so it never wraps
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            clear_prev_ff <= 1'b0;
            high_cnt_ff   <= 32'h0000_0000;
        end else begin
            clear_prev_ff <= clear_in;
            if (!clear_in)
                high_cnt_ff <= 32'h0000_0000;
            else if (high_cnt_ff <= MAX_HIGH)
                high_cnt_ff <= high_cnt_ff + 32'h0000_0001;
        end
    end

    // Pulse judged on the falling edge; too short or too long is dropped
    assign valid_pulse = clear_prev_ff && !clear_in
                         && (high_cnt_ff >= min_cyc)
                         && (high_cnt_ff <= MAX_HIGH);
endmodule

//--- tb.sv
// Self-checking bench for the press setup release block.
// Assumes shortened clear timings: minimum 10 or 35 cycles, maximum 300.
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0000_0000, hrdata;
    logic        hreadyout, hresp, run_cmd = 1'b0, start_permit = 1'b1;
    logic        press_permit, clear_pending, main_permit_n, main_permit;
    logic        main_req = 1'b1, stroke_go = 1'b0, clear_go = 1'b0, stroke_end, clear_in;
    logic [15:0] clear_len = 16'h0000;
    int          bad_count = 0, tests_run = 0, cycles = 0;

    psr_release #(.MIN_SHORT(32'h0000_000A), .MIN_LONG(32'h0000_0023),
                  .MAX_HIGH(32'h0000_012C)) DUT (
        .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .run_cmd(run_cmd),
        .main_permit(main_permit), .start_permit(start_permit), .stroke_end(stroke_end),
        .clear_in(clear_in), .press_permit(press_permit), .clear_pending(clear_pending),
        .main_permit_n(main_permit_n));
    psr_monitor_model u_far (.clock(clock), .main_req(main_req), .stroke_go(stroke_go),
        .clear_go(clear_go), .clear_len(clear_len), .main_permit(main_permit),
        .stroke_end(stroke_end), .clear_in(clear_in));

    always #5 clock = ~clock;
    // Hang guard: far beyond the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // One single AHB-Lite transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0000_0000, q);
        chk(n, q, e);
    endtask
    task automatic run(input logic v);
        @(posedge clock) run_cmd <= v;
        repeat (4) @(posedge clock);
    endtask
    task automatic pulse(input logic [15:0] n);
        @(posedge clock) clear_len <= n;
        clear_go <= 1'b1;
        @(posedge clock) clear_go <= 1'b0;
        repeat (n + 6) @(posedge clock);
    endtask
    task automatic stroke();
        @(posedge clock) stroke_go <= 1'b1;
        repeat (8) @(posedge clock);
        chk("stroke drop", press_permit, 1'b0);
        stroke_go <= 1'b0;
    endtask
    task automatic t_regs();
        rd(12'h000, 32'h0000_0002, "ctrl reset");
        wr(12'h000, 32'h0000_00FF);
        rd(12'h000, 32'h0000_003F, "ctrl rw");
        wr(12'h004, 32'h0000_0000);
        rd(12'h004, 32'h0000_0066, "status");
        rd(12'h010, 32'h0000_0000, "unmapped");
        wr(12'h000, 32'h0000_0002);
        $display("test regs done");
    endtask
    task automatic t_clear();
        run(1'b1);
        chk("held low", press_permit, 1'b0);
        run(1'b0);
        pulse(16'h0005);
        chk("short pulse", clear_pending, 1'b1);
        pulse(16'h0131);
        chk("long pulse", clear_pending, 1'b1);
        pulse(16'h000A);
        chk("min pulse", clear_pending, 1'b0);
        run(1'b1);
        chk("permit rise", press_permit, 1'b1);
        run(1'b0);
        chk("run fall", press_permit, 1'b0);
        chk("rearm", clear_pending, 1'b1);
        $display("test clear done");
    endtask
    task automatic t_modes();
        wr(12'h000, 32'h0000_0003);
        pulse(16'h000A);
        run(1'b1);
        @(posedge clock) main_req <= 1'b0;
        repeat (4) @(posedge clock);
        chk("main low", press_permit, 1'b0);
        chk("inverted", main_permit_n, 1'b1);
        chk("no pending", clear_pending, 1'b0);
        @(posedge clock) main_req <= 1'b1;
        repeat (4) @(posedge clock);
        chk("inverted", main_permit_n, 1'b0);
        chk("main rearm", clear_pending, 1'b1);
        wr(12'h000, 32'h0000_0014);
        run(1'b0);
        pulse(16'h000A);
        run(1'b1);
        stroke();
        chk("stroke rearm", clear_pending, 1'b1);
        run(1'b0);
        pulse(16'h000A);
        run(1'b1);
        run(1'b0);
        chk("run no rearm", clear_pending, 1'b0);
        $display("test modes done");
    endtask
    task automatic t_none();
        wr(12'h000, 32'h0000_0011);
        run(1'b1);
        stroke();
        chk("none pending", clear_pending, 1'b0);
        run(1'b0);
        run(1'b1);
        chk("none restart", press_permit, 1'b1);
        run(1'b0);
        $display("test none done");
    endtask
    task automatic t_start();
        wr(12'h000, 32'h0000_0009);
        @(posedge clock) start_permit <= 1'b0;
        run(1'b1);
        chk("start gate", press_permit, 1'b0);
        run(1'b0);
        @(posedge clock) start_permit <= 1'b1;
        run(1'b1);
        @(posedge clock) start_permit <= 1'b0;
        repeat (4) @(posedge clock);
        chk("start ignored", press_permit, 1'b1);
        run(1'b0);
        start_permit <= 1'b1;
        $display("test start done");
    endtask
    task automatic t_long();
        wr(12'h000, 32'h0000_0022);
        run(1'b1);
        run(1'b0);
        pulse(16'h0014);
        chk("below long min", clear_pending, 1'b1);
        pulse(16'h0023);
        chk("long min", clear_pending, 1'b0);
        $display("test long done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence: reset for four cycles, then every scenario in turn
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_clear();
        t_modes();
        t_none();
        t_start();
        t_long();
        tally_and_finish();
    end
endmodule
